// *** src/lmcr_memcfg.sv ***
// Purpose : Memory configuration register and the side effects of writing it.
// Assumes : Host write strobe is one cycle, synchronous to sys_clk.
// Notes   : Outputs are all registered; pulses last one cycle.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Host writes zero to reserved bits unless another value is given.
// [R2] Not-applicable bits 7 and 6 store nothing and steer nothing.
// [R3] Any write resets timing, disables display; indirect mode also leaves power save.
// [R4] Indirect configuration command carries registers 0 to 7, then leaves power save.
// [R5] Bit 5 low shifts text one line down against graphics.
// [R6] Pixel scroll shifts the text layer right by one to seven pixels.
// [R7] Reserved bit 4 resets to one; register resets to 10h.
// [R8] Reserved bit 1 resets to zero.
// [R9] Bit 3 picks single (0) or dual (1) panel drive.
// [R10] Bit 2 picks 8 or 16 pixel character height.
// [R11] Bit 0 picks character ROM (0) or character RAM (1).
// [R12] ROM holds 160 characters; RAM 256, or 64 beside the ROM.
// [R13] Fourth block start used only in dual drive; blocks one to three always.
// [R14] Host sets block line counts per drive mode.
// [R15] Cursor moves continuously over whole screen in both drive modes.
// [R16] Host may add one line to a block under origin compensation.
// [R17] Host programs even frame height in dual drive.
module lmcr_memcfg (
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  input  wire logic                indirect_mode,
  input  wire logic                wr_stb,
  input  wire logic [15:0]         wr_addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic                cmd_config,
  input  wire logic                rd_stb,
  input  wire logic [15:0]         rd_addr,
  input  wire logic [15:0]         block_one_start,
  input  wire logic [15:0]         block_two_start,
  input  wire logic [15:0]         block_three_start,
  input  wire logic [15:0]         block_four_start,
  input  wire logic [1:0]          block_sel,
  input  wire logic [8:0]          cursor_addr,
  input  wire logic [8:0]          cursor_limit,
  input  wire logic                cursor_step,
  input  wire logic [2:0]          pixel_scroll_command,
  input  wire logic                pix_valid,
  input  wire logic [7:0]          pix_in,
  output logic      [7:0]          rd_data,
  output logic                     timing_reset,
  output logic                     display_disable,
  output logic                     power_save_exit,
  output logic                     config_busy,
  output logic                     origin_compensation_on,
  output logic                     dual_panel,
  output logic      [4:0]          char_height,
  output logic                     char_source_select,
  output logic      [8:0]          char_rom_count,
  output logic      [8:0]          char_ram_count,
  output logic      [15:0]         block_start,
  output logic                     block_start_valid,
  output logic      [8:0]          cursor_next,
  output logic      [7:0]          text_pixels
);
  import lmcr_pkg::*;

  typedef struct packed {
    lmcr_state_t st;
    logic [3:0]  pcount;
    logic [7:0]  cfg;
    logic [7:0]  rd_data;
    logic        tg_rst;
    logic        disp_off;
    logic        ps_exit;
    logic [15:0] bstart;
    logic        bvalid;
    logic [8:0]  cursor;
    // Decoded copies of the stored byte, and the busy flag, kept as flops for the outputs
    logic        ocomp;
    logic [4:0]  height;
    logic [8:0]  rom_cnt;
    logic [8:0]  ram_cnt;
    logic        busy;
  } lmcr_state_s_t;

  lmcr_state_s_t s_r;
  lmcr_state_s_t s_nxt;
  logic          cfg_write;
  logic          in_set;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_nxt        = s_r;
    // Pulses drop back to zero unless set again below
    s_nxt.tg_rst = 1'b0;
    s_nxt.ps_exit = 1'b0;
    cfg_write    = wr_stb && (wr_addr == LMCR_ADDR_MEMCFG);
    in_set       = wr_stb && (wr_addr <= LMCR_ADDR_LAST_SET) && (wr_addr >= LMCR_ADDR_MEMCFG);

    // Bits 7 and 6 are dropped; reserved bits stored as written
    if (cfg_write) begin
      s_nxt.cfg      = wr_data & LMCR_STORE_MASK;   // see [R2]
      s_nxt.tg_rst   = 1'b1;                        // see [R3]
      s_nxt.disp_off = 1'b1;                        // see [R3]
    end

    // Indirect configuration: eight writes anywhere in the register set, counted in any order
    case (s_r.st)
      LMCR_IDLE: begin
        // Commands outside indirect mode have no meaning and are dropped
        if (indirect_mode && cmd_config) begin
          s_nxt.st     = LMCR_COLLECT;              // see [R4]
          s_nxt.pcount = 4'h0;
        end
      end
      LMCR_COLLECT: begin
        // Any address of the set counts; limitation: order is not checked
        // A second command while collecting is ignored and the count runs on
        if (in_set) begin
          s_nxt.pcount = s_r.pcount + 4'h1;
          if (s_r.pcount == LMCR_PARAM_COUNT - 4'h1) begin
            s_nxt.st      = LMCR_IDLE;
            s_nxt.ps_exit = 1'b1;                   // see [R4]
          end
        end
      end
      default: begin
        // Unused code: fall back to idle rather than hang
        s_nxt.st = LMCR_IDLE;
      end
    endcase
    // Direct write in indirect mode also completes power save exit
    if (cfg_write && indirect_mode && s_r.st == LMCR_IDLE) begin
      s_nxt.ps_exit = 1'b1;                         // see [R3]
    end

    // Host re-enables display elsewhere; here only the disable level
    if (!cfg_write && wr_stb && wr_addr == LMCR_ADDR_LAST_SET + 16'h2) begin
      s_nxt.disp_off = 1'b0;
    end

    // Read back
    // Only this register answers; other addresses leave the last value,
    // so the read bus stays steady between strobes
    s_nxt.rd_data = (rd_stb && rd_addr == LMCR_ADDR_MEMCFG) ? s_r.cfg : s_r.rd_data;

    // Block start pick; fourth only valid in dual drive
    // Single drive has no fourth block: zero, not a stale address
    case (block_sel)
      2'd0: s_nxt.bstart = block_one_start;         // see [R13]
      2'd1: s_nxt.bstart = block_two_start;
      2'd2: s_nxt.bstart = block_three_start;
      default: s_nxt.bstart = s_r.cfg[LMCR_BIT_DUAL] ? block_four_start : 16'h0000;
    endcase
    s_nxt.bvalid = (block_sel != 2'd3) || s_r.cfg[LMCR_BIT_DUAL];   // see [R13]

    // Cursor wraps over the whole screen in either drive mode
    // Limit is inclusive; the step past it wraps to address zero
    if (cursor_step) begin
      s_nxt.cursor = (cursor_addr >= cursor_limit) ? 9'h000 : cursor_addr + 9'h001;   // see [R15]
    end

    // ****************************************************************
    // Decoded outputs
    // ****************************************************************
    // Worked out from the next stored byte, so each output leaves a flop
    // and still changes on the same edge as the byte itself
    s_nxt.ocomp   = ~s_nxt.cfg[LMCR_BIT_ORIGIN];                                          // see [R5]
    s_nxt.height  = s_nxt.cfg[LMCR_BIT_HEIGHT] ? LMCR_HEIGHT_LARGE : LMCR_HEIGHT_SMALL;  // see [R10]
    // ROM out of use means no fixed glyphs; the RAM then gets all 256
    s_nxt.rom_cnt = s_nxt.cfg[LMCR_BIT_SRC] ? 9'h000 : LMCR_ROM_CHARS;                   // see [R12]
    s_nxt.ram_cnt = s_nxt.cfg[LMCR_BIT_SRC] ? LMCR_RAM_CHARS_FULL : LMCR_RAM_CHARS_ROM;  // see [R12]
    // Busy is a flop too, in step with the collector state
    s_nxt.busy    = (s_nxt.st == LMCR_COLLECT);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r          <= '0;
      s_r.cfg      <= LMCR_MEMCFG_RESET;   // see [R7] see [R8]
      s_r.disp_off <= 1'b1;
      // Decoded copies must agree with the reset byte from the first edge
      s_r.ocomp    <= ~LMCR_MEMCFG_RESET[LMCR_BIT_ORIGIN];
      s_r.height   <= LMCR_MEMCFG_RESET[LMCR_BIT_HEIGHT] ? LMCR_HEIGHT_LARGE : LMCR_HEIGHT_SMALL;
      s_r.rom_cnt  <= LMCR_MEMCFG_RESET[LMCR_BIT_SRC] ? 9'h000 : LMCR_ROM_CHARS;
      s_r.ram_cnt  <= LMCR_MEMCFG_RESET[LMCR_BIT_SRC] ? LMCR_RAM_CHARS_FULL : LMCR_RAM_CHARS_ROM;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Text layer shifter; zero shift when nothing is programmed
  // It keeps its own carry, so pixels cross byte edges and none are lost
  lmcr_scroll #(.W(8)) u_scroll (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .shift   (pixel_scroll_command),    // see [R6]
    .pix_valid(pix_valid),
    .pix_in  (pix_in),
    .pix_out (text_pixels)
  );

  // ****************************************************************
  // Outputs, straight from the register copy
  // ****************************************************************
  assign rd_data                = s_r.rd_data;
  assign timing_reset           = s_r.tg_rst;
  assign display_disable        = s_r.disp_off;
  assign power_save_exit        = s_r.ps_exit;
  // Decoded fields come from their own flops, not from gates on the byte
  assign config_busy            = s_r.busy;
  assign origin_compensation_on = s_r.ocomp;                   // see [R5]
  assign dual_panel             = s_r.cfg[LMCR_BIT_DUAL];      // see [R9]
  assign char_height            = s_r.height;                  // see [R10]
  assign char_source_select     = s_r.cfg[LMCR_BIT_SRC];       // see [R11]
  assign char_rom_count         = s_r.rom_cnt;                 // see [R12]
  assign char_ram_count         = s_r.ram_cnt;                 // see [R12]
  assign block_start            = s_r.bstart;
  assign block_start_valid      = s_r.bvalid;
  assign cursor_next            = s_r.cursor;
endmodule // lmcr_memcfg
`default_nettype wire

// *** src/lmcr_pkg.sv ***
// Purpose : Constants and types for the memory configuration register bank.
// Assumes : Byte-wide host writes, one system clock.
// Notes   : Offsets are host byte addresses.
package lmcr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] LMCR_ADDR_MEMCFG    = 16'h8000;
  localparam logic [15:0] LMCR_ADDR_LAST_SET  = 16'h8007;
  localparam logic [7:0]  LMCR_MEMCFG_RESET   = 8'h10;

  // ****************************************************************
  // Field positions of the memory configuration register
  // ****************************************************************
  localparam int LMCR_BIT_SRC    = 0;
  localparam int LMCR_BIT_RSV1   = 1;
  localparam int LMCR_BIT_HEIGHT = 2;
  localparam int LMCR_BIT_DUAL   = 3;
  localparam int LMCR_BIT_RSV4   = 4;
  localparam int LMCR_BIT_ORIGIN = 5;
  localparam logic [7:0] LMCR_STORE_MASK = 8'h3F;

  // ****************************************************************
  // Character generator figures
  // ****************************************************************
  localparam logic [8:0] LMCR_ROM_CHARS      = 9'h0A0;
  localparam logic [8:0] LMCR_RAM_CHARS_FULL = 9'h100;
  localparam logic [8:0] LMCR_RAM_CHARS_ROM  = 9'h040;
  localparam logic [4:0] LMCR_HEIGHT_SMALL   = 5'h08;
  localparam logic [4:0] LMCR_HEIGHT_LARGE   = 5'h10;
  localparam logic [2:0] LMCR_SCROLL_MAX     = 3'h7;
  localparam logic [3:0] LMCR_PARAM_COUNT    = 4'h8;

  // Collector states for the indirect configuration command
  typedef enum logic [1:0] {
    LMCR_IDLE,
    LMCR_COLLECT
  } lmcr_state_t;

endpackage : lmcr_pkg

// *** src/lmcr_scroll.sv ***
// Purpose : Text layer horizontal pixel shifter.
// Assumes : One pixel byte per clock, shift amount steady while used.
// Notes   : Bits pushed out on the right carry into the next byte.
`timescale 1ns/1ps
`default_nettype none
module lmcr_scroll #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [2:0]   shift,
  input  wire logic         pix_valid,
  input  wire logic [W-1:0] pix_in,
  output logic      [W-1:0] pix_out
);
  import lmcr_pkg::*;

  typedef struct packed {
    logic [W-1:0] carry;
    logic [W-1:0] out;
  } lmcr_sc_t;

  lmcr_sc_t s_r;
  lmcr_sc_t s_nxt;
  logic [2*W-1:0] wide;

  // ****************************************************************
  // Shift right by 0..7 with carry between bytes
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    wide  = {s_r.carry, pix_in} >> shift;   // see [R6]
    if (pix_valid) begin
      s_nxt.out   = wide[W-1:0];
      s_nxt.carry = pix_in;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pix_out = s_r.out;
endmodule // lmcr_scroll
`default_nettype wire

// *** testbench/lmcr_memcfg_monitor.sv ***
// Purpose: Port checks for the memory configuration register.
// Assumes: One clock, async low reset, registered outputs.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module lmcr_memcfg_monitor import lmcr_pkg::*; (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       indirect_mode,
  input wire logic       wr_stb,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       cmd_config,
  input wire logic       timing_reset,
  input wire logic       display_disable,
  input wire logic       power_save_exit,
  input wire logic       config_busy,
  input wire logic       origin_compensation_on,
  input wire logic       dual_panel,
  input wire logic [4:0] char_height,
  input wire logic       char_source_select,
  input wire logic [8:0] char_rom_count,
  input wire logic [8:0] char_ram_count
);
  // ****************************************************************
  // Write side effects and field decode
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence cfg_wr; wr_stb && wr_addr == LMCR_ADDR_MEMCFG; endsequence
  sequence cfg_cmd; cmd_config && indirect_mode && !config_busy; endsequence
  a_timing_reset_hit: assert property (cfg_wr |=> timing_reset)
    else $error("timing reset missing after write");
  a_timing_reset_cause: assert property (timing_reset |-> $past(wr_stb && wr_addr == LMCR_ADDR_MEMCFG))
    else $error("timing reset without write");
  a_display_off_write: assert property (cfg_wr |=> display_disable)
    else $error("display still enabled after write");
  a_psave_exit_write: assert property ((cfg_wr ##0 indirect_mode && !config_busy) |=> power_save_exit)
    else $error("power save not left");
  a_config_cmd_busy: assert property (cfg_cmd |=> config_busy)
    else $error("command not collecting");
  a_dual_drive_bit: assert property (cfg_wr |=> dual_panel == $past(wr_data[LMCR_BIT_DUAL]))
    else $error("drive select wrong");
  a_char_height_map: assert property (cfg_wr |=> char_height == ($past(wr_data[2]) ? 5'h10 : 5'h08))
    else $error("height wrong");
  a_origin_comp_inv: assert property (cfg_wr |=> origin_compensation_on != $past(wr_data[5]))
    else $error("origin compensation wrong");
  a_char_src_ram: assert property (cfg_wr |=> char_source_select == $past(wr_data[0])
    && char_ram_count == ($past(wr_data[0]) ? 9'h100 : 9'h040)) else $error("source wrong");
  a_rom_count_src: assert property (char_rom_count == (char_source_select ? 9'h000 : 9'h0A0))
    else $error("rom count wrong");
endmodule // lmcr_memcfg_monitor
`default_nettype wire

// *** testbench/lmcr_host.sv ***
// Purpose: Host model writing and reading the controller registers.
// Assumes: One-cycle strobes launched 1 ns after an edge.
// Notes: Idle lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module lmcr_host import lmcr_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_stb,
  output logic     [15:0] wr_addr,
  output logic     [7:0]  wr_data,
  output logic            rd_stb,
  output logic     [15:0] rd_addr,
  output logic            cmd_config
);
  // Quiet bus at time zero
  initial begin
    {wr_stb, rd_stb, cmd_config} = 3'h0;
    {wr_addr, rd_addr, wr_data} = 40'h0;
  end
  // Reserved bits forced to their documented levels, since others are undefined
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    wr_addr = a;
    wr_data = (a == LMCR_ADDR_MEMCFG) ? ((d & 8'hFD) | 8'h10) : d;
    wr_stb = 1'b1;
    @(posedge sys_clk) #1;
    wr_stb = 1'b0;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask
  // Read data lands on the same edge that takes the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    rd_addr = a;
    rd_stb = 1'b1;
    @(posedge sys_clk) #1;
    rd_stb = 1'b0;
    rd_addr = ~a;
    d = rd_data;
  endtask
  // Block line counts first, then the command and its eight parameter bytes
  task automatic cfg_cmd(input logic [63:0] p);
    logic [63:0] v;
    logic [7:0]  sl;
    v = p;
    // Dual drive needs an even frame height, so its register value is odd
    if (v[3]) v[47:40] = v[47:40] | 8'h01;
    // Dual: half the frame less one; single: room for one extra compensated line
    if (v[3]) sl = 8'((9'(v[47:40]) + 9'h001) >> 1) - 8'h01;
    else sl = (v[47:40] >> 1) + ((v[5] || v[47:40] == 8'h00) ? 8'h00 : 8'h01);
    wr(LMCR_ADDR_MEMCFG + 16'h000D, sl);
    wr(LMCR_ADDR_MEMCFG + 16'h0010, sl);
    @(posedge sys_clk) #1;
    cmd_config = 1'b1;
    @(posedge sys_clk) #1;
    cmd_config = 1'b0;
    for (int i = 0; i < 8; i++) wr(LMCR_ADDR_MEMCFG + 16'(i), v[8*i +: 8]);
  endtask
endmodule // lmcr_host
`default_nettype wire

// *** testbench/lmcr_memcfg_bench.sv ***
// Purpose: Self-checking bench for the memory configuration register.
// Assumes: 100 MHz clock, inputs moved 1 ns after the edge.
// Notes: Random data from a fixed seed with corner values mixed in.
`timescale 1ns/1ps
`default_nettype none
module lmcr_memcfg_bench import lmcr_pkg::*;;
  logic sys_clk, arst_n, indirect_mode, cmd_config, wr_stb, rd_stb, cursor_step, pix_valid;
  logic [15:0] wr_addr, rd_addr, block_one_start, block_two_start, block_three_start, block_four_start, block_start;
  logic [8:0] cursor_addr, cursor_limit, cursor_next, char_rom_count, char_ram_count;
  logic [7:0] wr_data, pix_in, rd_data, text_pixels, d, p, q;
  logic [63:0] prm;
  logic [4:0] char_height;
  logic [2:0] pixel_scroll_command;
  logic [1:0] block_sel;
  logic timing_reset, display_disable, power_save_exit, config_busy, origin_compensation_on;
  logic dual_panel, char_source_select, block_start_valid;
  int err_total, cmp_count, seed, k;
  lmcr_memcfg u_lmcr_memcfg (.sys_clk, .arst_n, .indirect_mode, .wr_stb, .wr_addr, .wr_data, .cmd_config,
    .rd_stb, .rd_addr, .block_one_start, .block_two_start, .block_three_start, .block_four_start, .block_sel,
    .cursor_addr, .cursor_limit, .cursor_step, .pixel_scroll_command, .pix_valid, .pix_in, .rd_data,
    .timing_reset, .display_disable, .power_save_exit, .config_busy, .origin_compensation_on, .dual_panel,
    .char_height, .char_source_select, .char_rom_count, .char_ram_count, .block_start, .block_start_valid,
    .cursor_next, .text_pixels);
  lmcr_host u_lmcr_host (.sys_clk, .rd_data, .wr_stb, .wr_addr, .wr_data, .rd_stb, .rd_addr, .cmd_config);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Expected valid flag and start address of the selected screen block
  function automatic logic [16:0] blk(input logic [1:0] s, input logic dual);
    case (s)
      2'h0: return {1'b1, block_one_start};
      2'h1: return {1'b1, block_two_start};
      2'h2: return {1'b1, block_three_start};
      default: return dual ? {1'b1, block_four_start} : 17'h0;
    endcase
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, far beyond the 140 or so cycles the tests take
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    seed = 11244;
    {err_total, cmp_count, arst_n, indirect_mode, cursor_step, pix_valid, pix_in, block_sel} = 0;
    {block_one_start, block_two_start, block_three_start, block_four_start} = {$random(seed), $random(seed)};
    {cursor_addr, cursor_limit, pixel_scroll_command} = 21'h0;
    repeat (5) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk(display_disable, 1'b1);
    u_lmcr_host.rd(LMCR_ADDR_MEMCFG, q);
    chk(q, LMCR_MEMCFG_RESET);
    for (k = 0; k < 12; k++) begin
      d = (k < 2) ? {8{k[0]}} : 8'($random(seed));
      block_sel = 2'(k);
      p = ((d & 8'hFD) | 8'h10) & LMCR_STORE_MASK;
      u_lmcr_host.wr(LMCR_ADDR_MEMCFG, d);
      chk({timing_reset, display_disable, power_save_exit}, 3'h6);
      chk({dual_panel, char_height}, {p[3], p[2] ? 5'h10 : 5'h08});
      chk({origin_compensation_on, char_source_select}, {!p[5], p[0]});
      chk({char_ram_count, char_rom_count}, p[0] ? 18'h20000 : 18'h080A0);
      @(posedge sys_clk) #1;
      chk(timing_reset, 1'b0);
      chk({block_start_valid, block_start}, blk(block_sel, p[3]));
      u_lmcr_host.rd(LMCR_ADDR_MEMCFG, q);
      chk(q, p);
      u_lmcr_host.wr(16'h8009, 8'h01);
      chk(display_disable, 1'b0);
    end
    $display("test direct writes done");
    indirect_mode = 1'b1;
    u_lmcr_host.wr(LMCR_ADDR_MEMCFG, 8'h21);
    chk(power_save_exit, 1'b1);
    prm = {$random(seed), $random(seed)};
    // The exit pulse stands at the edge that takes the eighth byte
    u_lmcr_host.cfg_cmd(prm);
    chk({power_save_exit, config_busy}, 2'h2);
    u_lmcr_host.rd(LMCR_ADDR_MEMCFG, q);
    chk(q, ((prm[7:0] & 8'hFD) | 8'h10) & LMCR_STORE_MASK);
    $display("test configuration command done");
    for (k = 0; k < 8; k++) begin
      pixel_scroll_command = 3'(k);
      d = 8'($random(seed));
      p = 8'($random(seed));
      {pix_valid, pix_in} = {1'b1, d};
      @(posedge sys_clk) #1;
      pix_in = p;
      @(posedge sys_clk) #1;
      pix_valid = 1'b0;
      q = 8'({d, p} >> k);
      chk(text_pixels, q);
    end
    $display("test pixel scroll done");
    cursor_limit = 9'h0FF;
    for (k = 0; k < 2; k++) begin
      {cursor_step, cursor_addr} = {1'b1, k[0] ? 9'h0FE : 9'h0FF};
      @(posedge sys_clk) #1;
      cursor_step = 1'b0;
      chk(cursor_next, k[0] ? 9'h0FF : 9'h000);
    end
    $display("test cursor done");
    // Mid-run reset with the display enabled and a non-default byte stored
    u_lmcr_host.wr(16'h8009, 8'h01);
    arst_n = 1'b0;
    @(posedge sys_clk) #1 arst_n = 1'b1;
    chk({display_disable, timing_reset, power_save_exit, config_busy}, 4'h8);
    chk({origin_compensation_on, char_height}, {1'b1, LMCR_HEIGHT_SMALL});
    chk(char_rom_count, LMCR_ROM_CHARS);
    u_lmcr_host.rd(LMCR_ADDR_MEMCFG, q);
    chk(q, LMCR_MEMCFG_RESET);
    $display("test reset again done");
    complete_run();
  end
endmodule // lmcr_memcfg_bench
bind lmcr_memcfg lmcr_memcfg_monitor u_lmcr_memcfg_monitor (.sys_clk, .arst_n, .indirect_mode, .wr_stb,
  .wr_addr, .wr_data, .cmd_config, .timing_reset, .display_disable, .power_save_exit, .config_busy,
  .origin_compensation_on, .dual_panel, .char_height, .char_source_select, .char_rom_count, .char_ram_count);
`default_nettype wire
